/* verilog/dps_pkg.sv */
package dps_pkg;
   // array shape: 8k words of 9 bits
   localparam int ADDR_W = 13;
   localparam int DATA_W = 9;
   localparam int DEPTH = 8192;
   localparam int NPORT = 2;
   localparam logic [ADDR_W-1:0] CNT_CLEAR_VAL = 13'h0000;
   localparam logic [ADDR_W-1:0] CNT_STEP = 13'h0001;
   // port to port timing, ns and MCLK cycles
   localparam int MCLK_PERIOD_NS = 4;
   localparam int CLOCK_OFFSET_WINDOW_NS = 15;
   localparam int WRITE_TO_READ_DELAY_NS = 40;
   // longest time rounds down, never below one cycle
   localparam int OFFSET_CYC = (CLOCK_OFFSET_WINDOW_NS / MCLK_PERIOD_NS < 1) ? 1 :
                               CLOCK_OFFSET_WINDOW_NS / MCLK_PERIOD_NS;
   // least time rounds up
   localparam int WTR_CYC = (WRITE_TO_READ_DELAY_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
   localparam int AGE_W = $clog2(WTR_CYC + 1);
   // layout of the synchronised pin bundle of one port
   localparam int SY_CLK = 0;
   localparam int SY_ADS = 1;
   localparam int SY_CEN = 2;
   localparam int SY_CLR = 3;
   localparam int SY_CE0 = 4;
   localparam int SY_CE1 = 5;
   localparam int SY_WNR = 6;
   localparam int SY_OE = 7;
   localparam int SY_MODE = 8;
   localparam int SY_ADDR = 9;
   localparam int SY_DATA = SY_ADDR + ADDR_W;
   localparam int SY_W = SY_DATA + DATA_W;
   // apb register map
   localparam int APB_AW = 12;
   localparam int APB_DW = 32;
   localparam int CTRL_W = 2;
   localparam logic [APB_AW-1:0] REG_PORT_CTRL = 12'h000;
   localparam logic [APB_AW-1:0] REG_CNT_A = 12'h004;
   localparam logic [APB_AW-1:0] REG_CNT_B = 12'h008;
   localparam logic [CTRL_W-1:0] CTRL_RST = 2'h3;
   localparam logic [APB_DW-1:0] RDATA_ZERO = 32'h0000_0000;
   typedef enum logic [1:0] {GRD_IDLE = 2'b01, GRD_WAIT = 2'b10} dps_grd_t;
endpackage : dps_pkg

/* verilog/dps_port_if.sv */
`timescale 1ns/1ps
interface dps_port_if;
   logic tick;
   logic [dps_pkg::ADDR_W-1:0] acc_addr;
   logic [dps_pkg::ADDR_W-1:0] cnt;
   logic [dps_pkg::DATA_W-1:0] wdata;
   logic do_write;
   logic do_read;
   logic selected;
   logic piped;
   logic drive_ok;
   modport ctl (output tick, acc_addr, cnt, wdata, do_write, do_read, selected, piped, drive_ok);
   modport core (input tick, acc_addr, cnt, wdata, do_write, do_read, selected, piped, drive_ok);
endinterface : dps_port_if

/* verilog/dps_port_ctrl.sv */
`timescale 1ns/1ps
module dps_port_ctrl (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic tick,
   input wire logic [dps_pkg::SY_W-1:0] pins,
   dps_port_if.ctl pif
);
   localparam int AW = dps_pkg::ADDR_W;
   logic [AW-1:0] cnt_ff;
   logic [AW-1:0] nxt_cnt;
   logic [AW-1:0] ext_addr;
   logic clr_n;
   logic ads_n;
   logic cen_n;

   // sampled controls, already aligned with the port clock edge
   assign clr_n = pins[dps_pkg::SY_CLR];
   assign ads_n = pins[dps_pkg::SY_ADS];
   assign cen_n = pins[dps_pkg::SY_CEN];
   assign ext_addr = pins[dps_pkg::SY_ADDR +: AW];

   // burst counter: clear, load, increment, else hold; selects play no part
   always_comb begin
      nxt_cnt = cnt_ff;
      if (tick) begin
         if (!clr_n) begin
            nxt_cnt = dps_pkg::CNT_CLEAR_VAL; // [R6] [R10] [R11]
         end else if (!ads_n) begin
            nxt_cnt = ext_addr; // [R7]
         end else if (!cen_n) begin
            nxt_cnt = cnt_ff + dps_pkg::CNT_STEP; // [R9] [R17] [R19]
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff <= dps_pkg::CNT_CLEAR_VAL;
      end else begin
         cnt_ff <= nxt_cnt; // [R8]
      end
   end

   // access address is the new counter value, so a load reaches the array at once
   assign pif.tick = tick;
   assign pif.acc_addr = nxt_cnt; // [R12]
   assign pif.cnt = cnt_ff;
   assign pif.wdata = pins[dps_pkg::SY_DATA +: dps_pkg::DATA_W];
   assign pif.selected = !pins[dps_pkg::SY_CE0] && pins[dps_pkg::SY_CE1]; // [R1]
   assign pif.do_write = pif.selected && !pins[dps_pkg::SY_WNR]; // [R2]
   assign pif.do_read = pif.selected && pins[dps_pkg::SY_WNR];
   assign pif.piped = pins[dps_pkg::SY_MODE]; // [R16]
   assign pif.drive_ok = !pins[dps_pkg::SY_OE]; // [R3]

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_clear_first: assert property (tick && !clr_n |=> cnt_ff == dps_pkg::CNT_CLEAR_VAL) // [R6] [R11]
      else $error("counter not cleared");
   a_load_ext: assert property (tick && clr_n && !ads_n |=> cnt_ff == $past(ext_addr)) // [R7]
      else $error("counter did not load address");
   a_hold_cnt: assert property (tick && clr_n && ads_n && cen_n |=> $stable(cnt_ff)) // [R8]
      else $error("counter moved on hold");
   a_incr_wrap: assert property (tick && clr_n && ads_n && !cen_n |=> cnt_ff == AW'($past(cnt_ff) + 1)) // [R9]
      else $error("counter did not step by one");
   a_desel_counts: assert property (tick && !pif.selected && clr_n && ads_n && !cen_n // [R10]
                                    |=> cnt_ff != $past(cnt_ff))
      else $error("counter stalled while deselected");
   a_addr_pick: assert property (tick && clr_n && !ads_n |-> pif.acc_addr == ext_addr) // [R12]
      else $error("strobe did not select pin address");
   // a held counter must feed the array, not the ignored pin address
   a_burst_addr: assert property (tick && clr_n && ads_n && cen_n |-> pif.acc_addr == cnt_ff) // [R12]
      else $error("access address is not counter output");
   c_wrap: cover property (tick && ads_n && clr_n && !cen_n && cnt_ff == {AW{1'b1}});
endmodule : dps_port_ctrl

/* verilog/dps_rw_guard.sv */
`timescale 1ns/1ps
module dps_rw_guard (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic wr_tick,
   input wire logic [dps_pkg::ADDR_W-1:0] wr_addr,
   input wire logic rd_tick,
   input wire logic [dps_pkg::ADDR_W-1:0] rd_addr,
   output logic refetch
);
   localparam int AGW = dps_pkg::AGE_W;
   localparam int WTR_B = dps_pkg::WTR_CYC;
   dps_pkg::dps_grd_t state_ff;
   dps_pkg::dps_grd_t nxt_state;
   logic [AGW-1:0] age_ff;
   logic [AGW-1:0] nxt_age;
   logic [AGW-1:0] wait_ff;
   logic [AGW-1:0] nxt_wait;
   logic [dps_pkg::ADDR_W-1:0] waddr_ff;
   logic [dps_pkg::ADDR_W-1:0] nxt_waddr;
   logic hit;

   // a read of the word just written by the far port, inside the offset window
   assign hit = rd_tick && (wr_tick ? rd_addr == wr_addr :
                (rd_addr == waddr_ff && age_ff <= AGW'(dps_pkg::OFFSET_CYC)));

   // age of the far write saturates, so a stale write never matches
   always_comb begin
      nxt_age = (age_ff < AGW'(WTR_B)) ? age_ff + 1'b1 : age_ff;
      nxt_waddr = waddr_ff;
      nxt_state = state_ff;
      nxt_wait = wait_ff;
      refetch = 1'b0;
      if (wr_tick) begin
         nxt_age = AGW'(1);
         nxt_waddr = wr_addr;
      end
      case (state_ff)
         dps_pkg::GRD_IDLE: begin
            if (hit) begin
               nxt_state = dps_pkg::GRD_WAIT;
               nxt_wait = wr_tick ? AGW'(WTR_B) : AGW'(WTR_B) - age_ff; // [R15]
            end
         end
         dps_pkg::GRD_WAIT: begin
            if (wait_ff <= AGW'(1)) begin
               refetch = 1'b1; // [R15]
               nxt_state = dps_pkg::GRD_IDLE;
            end else begin
               nxt_wait = wait_ff - 1'b1;
            end
         end
         default: nxt_state = dps_pkg::GRD_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= dps_pkg::GRD_IDLE;
         age_ff <= AGW'(WTR_B);
         wait_ff <= '0;
         waddr_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         age_ff <= nxt_age;
         wait_ff <= nxt_wait;
         waddr_ff <= nxt_waddr;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_refetch_due: assert property (state_ff == dps_pkg::GRD_IDLE && hit |-> ##[1:WTR_B] refetch) // [R15]
      else $error("late refetch after collision");
   a_refetch_late: assert property (state_ff == dps_pkg::GRD_IDLE && hit && wr_tick |=> !refetch [*8]) // [R15]
      else $error("refetch before write settled");
   c_collide: cover property (hit ##[1:WTR_B] refetch);
endmodule : dps_rw_guard

/* verilog/dps_top.sv */
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
// How it works
// [R1] deselected at an edge, the port's data pins float after that edge
// [R2] both selects active and write level low at an edge store the data word
// [R3] output drive input alone floats or enables the pins, apart from any edge
// [R4] in piped mode select changes show one port cycle later
// [R5] piped read data passes one extra register, one port cycle later
// [R6] counter clear low sets the counter to zero over strobe and enable
// [R7] strobe low with clear high loads the pin address into the counter
// [R8] strobe, enable and clear all high hold the counter and ignore pins
// [R9] enable low with strobe and clear high steps the counter by one
// [R10] the counter acts whatever the two select inputs are
// [R11] a read or write may share the cycle of a counter clear
// [R12] access address is the pins under strobe, else the counter output
// [R13] pin state in a cycle follows controls sampled at the previous edge
// [R14] after a no-operation cycle the host should rewrite the selected word
// [R15] read right after a far write on one word settles forty ns after it; the code repairs only the flow register, not a piped copy
// [R16] mode pin low gives flow-through output, high gives piped output
// [R17] the counter spans the whole array and wraps to the first word
// [R18] each port has its own decode and counter and never sees the other
// [R19] counter and access address are thirteen bits for 8192 words
module dps_top (
   input wire logic MCLK,
   input wire logic ARST_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic A_CLK,
   input wire logic [12:0] A_ADDR,
   input wire logic [8:0] A_DQ_IN,
   output logic [8:0] A_DQ_OUT,
   output logic A_DQ_OE,
   input wire logic A_ADDRESS_STROBE_N,
   input wire logic A_COUNT_ENABLE_N,
   input wire logic A_COUNTER_CLEAR_N,
   input wire logic A_SELECT_LOW_ACTIVE_N,
   input wire logic A_SELECT_HIGH_ACTIVE,
   input wire logic A_WRITE_NOT_READ,
   input wire logic A_OUTPUT_DRIVE_N,
   input wire logic A_FLOWTHRU_OR_PIPED_SEL,
   input wire logic B_CLK,
   input wire logic [12:0] B_ADDR,
   input wire logic [8:0] B_DQ_IN,
   output logic [8:0] B_DQ_OUT,
   output logic B_DQ_OE,
   input wire logic B_ADDRESS_STROBE_N,
   input wire logic B_COUNT_ENABLE_N,
   input wire logic B_COUNTER_CLEAR_N,
   input wire logic B_SELECT_LOW_ACTIVE_N,
   input wire logic B_SELECT_HIGH_ACTIVE,
   input wire logic B_WRITE_NOT_READ,
   input wire logic B_OUTPUT_DRIVE_N,
   input wire logic B_FLOWTHRU_OR_PIPED_SEL
);
   localparam int NP = dps_pkg::NPORT;
   localparam int SW = dps_pkg::SY_W;
   localparam int AW = dps_pkg::ADDR_W;
   localparam int DW = dps_pkg::DATA_W;
   localparam int BW = dps_pkg::APB_DW;

   logic [SW-1:0] raw [NP];
   logic [SW-1:0] s1_ff [NP];
   logic [SW-1:0] s2_ff [NP];
   logic [SW-1:0] nxt_s1 [NP];
   logic [SW-1:0] nxt_s2 [NP];
   logic [NP-1:0] clk_prev_ff;
   logic [NP-1:0] nxt_clk_prev;
   logic [NP-1:0] tick;
   logic [AW-1:0] acc_v [NP];
   logic [AW-1:0] cnt_v [NP];
   logic [DW-1:0] wdata_v [NP];
   logic [NP-1:0] sel_v;
   logic [NP-1:0] piped_v;
   logic [NP-1:0] drive_v;
   logic [NP-1:0] rd_hit;
   logic [NP-1:0] wr_hit;
   logic [NP-1:0] refetch;
   logic [DW-1:0] mem_ff [dps_pkg::DEPTH];
   logic [DW-1:0] flow_dat_ff [NP];
   logic [DW-1:0] nxt_flow_dat [NP];
   logic [DW-1:0] pipe_dat_ff [NP];
   logic [DW-1:0] nxt_pipe_dat [NP];
   logic [AW-1:0] rd_addr_ff [NP];
   logic [AW-1:0] nxt_rd_addr [NP];
   logic [NP-1:0] flow_drv_ff;
   logic [NP-1:0] nxt_flow_drv;
   logic [NP-1:0] pipe_drv_ff;
   logic [NP-1:0] nxt_pipe_drv;
   logic [NP-1:0] dq_oe;
   logic [dps_pkg::CTRL_W-1:0] en_ff;
   logic [dps_pkg::CTRL_W-1:0] nxt_en;
   logic [BW-1:0] rdat_ff;
   logic [BW-1:0] nxt_rdat;

   // gather each port's pins into one bundle, in package layout order
   always_comb begin
      raw[0] = {A_DQ_IN, A_ADDR, A_FLOWTHRU_OR_PIPED_SEL, A_OUTPUT_DRIVE_N, A_WRITE_NOT_READ,
                A_SELECT_HIGH_ACTIVE, A_SELECT_LOW_ACTIVE_N, A_COUNTER_CLEAR_N,
                A_COUNT_ENABLE_N, A_ADDRESS_STROBE_N, A_CLK};
      raw[1] = {B_DQ_IN, B_ADDR, B_FLOWTHRU_OR_PIPED_SEL, B_OUTPUT_DRIVE_N, B_WRITE_NOT_READ,
                B_SELECT_HIGH_ACTIVE, B_SELECT_LOW_ACTIVE_N, B_COUNTER_CLEAR_N,
                B_COUNT_ENABLE_N, B_ADDRESS_STROBE_N, B_CLK};
   end

   // two-stage sync of clock and controls together keeps setup alignment
   always_comb begin
      for (int p = 0; p < NP; p++) begin
         nxt_s1[p] = raw[p];
         nxt_s2[p] = s1_ff[p];
         nxt_clk_prev[p] = s2_ff[p][dps_pkg::SY_CLK];
         tick[p] = s2_ff[p][dps_pkg::SY_CLK] && !clk_prev_ff[p];
      end
   end

   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         for (int p = 0; p < NP; p++) begin
            s1_ff[p] <= '0;
            s2_ff[p] <= '0;
         end
         clk_prev_ff <= '0;
      end else begin
         s1_ff <= nxt_s1;
         s2_ff <= nxt_s2;
         clk_prev_ff <= nxt_clk_prev;
      end
   end

   dps_port_if pif [NP] ();

   // one decoder, counter and collision guard per port
   for (genvar p = 0; p < NP; p++) begin : g_port
      dps_port_ctrl u_ctrl (
         .clk(MCLK),
         .rst_n(ARST_N),
         .tick(tick[p]),
         .pins(s2_ff[p]),
         .pif(pif[p])
      ); // [R18]
      assign acc_v[p] = pif[p].acc_addr;
      assign cnt_v[p] = pif[p].cnt;
      assign wdata_v[p] = pif[p].wdata;
      assign sel_v[p] = pif[p].selected;
      assign piped_v[p] = pif[p].piped;
      assign drive_v[p] = pif[p].drive_ok;
      // a port disabled in software behaves as deselected
      assign rd_hit[p] = tick[p] && pif[p].do_read && en_ff[p];
      assign wr_hit[p] = tick[p] && pif[p].do_write && en_ff[p]; // [R2]
      dps_rw_guard u_guard (
         .clk(MCLK),
         .rst_n(ARST_N),
         .wr_tick(wr_hit[NP-1-p]),
         .wr_addr(acc_v[NP-1-p]),
         .rd_tick(rd_hit[p]),
         .rd_addr(acc_v[p]),
         .refetch(refetch[p])
      ); // [R15]
      // output drive is gated last, so it floats the pins at any time
      assign dq_oe[p] = (piped_v[p] ? pipe_drv_ff[p] : flow_drv_ff[p]) && drive_v[p] && en_ff[p]; // [R3]
   end

   // array writes; on a same-word clash port b lands last and wins
   always_ff @(posedge MCLK) begin
      for (int p = 0; p < NP; p++) begin
         if (wr_hit[p]) begin
            mem_ff[acc_v[p]] <= wdata_v[p]; // [R2] [R11]
         end
      end
   end

   // read path: flow register at the edge, piped register one port edge on
   always_comb begin
      for (int p = 0; p < NP; p++) begin
         nxt_flow_dat[p] = flow_dat_ff[p];
         nxt_pipe_dat[p] = pipe_dat_ff[p];
         nxt_rd_addr[p] = rd_addr_ff[p];
         nxt_flow_drv[p] = flow_drv_ff[p];
         nxt_pipe_drv[p] = pipe_drv_ff[p];
         if (tick[p]) begin
            nxt_pipe_dat[p] = flow_dat_ff[p]; // [R5]
            nxt_pipe_drv[p] = flow_drv_ff[p]; // [R4]
            nxt_flow_drv[p] = rd_hit[p]; // [R1] [R13]
            if (rd_hit[p]) begin
               nxt_flow_dat[p] = mem_ff[acc_v[p]];
               nxt_rd_addr[p] = acc_v[p];
            end
         end else if (refetch[p]) begin
            // only the flow register is repaired; a piped copy already taken stays
            nxt_flow_dat[p] = mem_ff[rd_addr_ff[p]]; // [R15]
         end
      end
   end

   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         for (int p = 0; p < NP; p++) begin
            flow_dat_ff[p] <= '0;
            pipe_dat_ff[p] <= '0;
            rd_addr_ff[p] <= '0;
         end
         flow_drv_ff <= '0;
         pipe_drv_ff <= '0;
      end else begin
         flow_dat_ff <= nxt_flow_dat;
         pipe_dat_ff <= nxt_pipe_dat;
         rd_addr_ff <= nxt_rd_addr;
         flow_drv_ff <= nxt_flow_drv;
         pipe_drv_ff <= nxt_pipe_drv;
      end
   end

   // pin outputs; mode pin is static, so the mux only picks a flop
   assign A_DQ_OUT = piped_v[0] ? pipe_dat_ff[0] : flow_dat_ff[0]; // [R16]
   assign B_DQ_OUT = piped_v[1] ? pipe_dat_ff[1] : flow_dat_ff[1];
   assign A_DQ_OE = dq_oe[0];
   assign B_DQ_OE = dq_oe[1];

   function automatic logic reg_hit(input logic [dps_pkg::APB_AW-1:0] a);
      return a == dps_pkg::REG_PORT_CTRL || a == dps_pkg::REG_CNT_A || a == dps_pkg::REG_CNT_B;
   endfunction : reg_hit

   // apb: read data captured in setup, zero wait state access
   always_comb begin
      nxt_en = en_ff;
      nxt_rdat = rdat_ff;
      if (PSEL && !PENABLE) begin
         case (PADDR)
            dps_pkg::REG_PORT_CTRL: nxt_rdat = BW'(en_ff);
            dps_pkg::REG_CNT_A: nxt_rdat = BW'(cnt_v[0]);
            dps_pkg::REG_CNT_B: nxt_rdat = BW'(cnt_v[1]);
            default: nxt_rdat = dps_pkg::RDATA_ZERO;
         endcase
      end
      if (PSEL && PENABLE && PWRITE && PADDR == dps_pkg::REG_PORT_CTRL) begin
         nxt_en = PWDATA[dps_pkg::CTRL_W-1:0];
      end
   end

   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         en_ff <= dps_pkg::CTRL_RST;
         rdat_ff <= dps_pkg::RDATA_ZERO;
      end else begin
         en_ff <= nxt_en;
         rdat_ff <= nxt_rdat;
      end
   end

   assign PRDATA = rdat_ff;
   assign PREADY = PSEL && PENABLE;
   assign PSLVERR = PSEL && PENABLE && !reg_hit(PADDR);

   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!ARST_N);

   for (genvar p = 0; p < NP; p++) begin : g_chk
      a_desel_float: assert property (tick[p] && !sel_v[p] && !piped_v[p] |=> !dq_oe[p]) // [R1]
         else $error("deselected flow port still drives");
      a_write_store: assert property (wr_hit[p] && !(wr_hit[NP-1-p] && acc_v[0] == acc_v[1]) // [R2]
                                      |=> mem_ff[$past(acc_v[p])] == $past(wdata_v[p]))
         else $error("write word not stored");
      a_oe_float: assert property (!drive_v[p] |-> !dq_oe[p]) // [R3]
         else $error("pins driven with output drive high");
      a_pipe_lag: assert property (tick[p] && piped_v[p] && !flow_drv_ff[p] |=> !dq_oe[p]) // [R4] [R5]
         else $error("piped port drove one cycle early");
      a_pipe_follow: assert property (tick[p] && piped_v[p] && flow_drv_ff[p] // [R5]
                                      |=> dq_oe[p] || !drive_v[p] || !en_ff[p])
         else $error("piped read data missing");
      // flow data must be the word the array held at the read edge
      a_flow_now: assert property (rd_hit[p] && !piped_v[p] // [R13]
                                   |=> flow_dat_ff[p] == $past(mem_ff[acc_v[p]])
                                       && (dq_oe[p] || !drive_v[p] || !en_ff[p]))
         else $error("flow read did not drive");
      c_pipe_read: cover property (rd_hit[p] && piped_v[p]);
      c_flow_write: cover property (wr_hit[p] && !piped_v[p]);
   end
   c_apb_err: cover property (PSLVERR);
endmodule : dps_top

/* dv/dps_host.sv */
`timescale 1ns/1ps
// host controller on one memory port, makes its own port clock
module dps_host #(
   parameter logic PIPED = 1'b0
) (
   input wire logic mclk,
   output logic pclk,
   output logic [12:0] addr,
   output logic [8:0] dq,
   output logic [6:0] ctl,
   output logic mode
);
   // output mode is strapped, never changed in a run
   assign mode = PIPED;
   // idle pins: deselected, clock low
   initial begin
      pclk = 1'b0;
      ctl = 7'h7E;
      addr = 13'h0000;
      dq = 9'h000;
   end
   // one port cycle; pins settle 4 mclk before the rise, since the block samples them through two flops
   task automatic cyc(input logic [6:0] c, input logic [12:0] a, input logic [8:0] d);
      @(posedge mclk);
      ctl <= c;
      addr <= a;
      dq <= c[1] ? ~dq : d;
      repeat (4) @(posedge mclk);
      pclk <= 1'b1;
      repeat (4) @(posedge mclk);
      pclk <= 1'b0;
   endtask : cyc
endmodule : dps_host

/* dv/tb.sv */
`timescale 1ns/1ps
module tb;
   // control codes: strobe_n, enable_n, clear_n, sel_low_n, sel_high, write_not_read, drive_n
   localparam logic [6:0] RD_LD = 7'h36;
   localparam logic [6:0] WR_LD = 7'h34;
   localparam logic [6:0] RD_INC = 7'h56;
   localparam logic [6:0] WR_INC = 7'h54;
   localparam logic [6:0] RD_HOLD = 7'h76;
   localparam logic [6:0] CLR_ALL = 7'h06;
   localparam logic [6:0] DS_INC = 7'h5E;
   localparam logic [6:0] DS_H = 7'h32;
   localparam logic [6:0] RD_OEH = 7'h37;
   localparam logic [6:0] IDLE = 7'h7E;
   localparam logic [33:0] WOK = 34'h2_0000_0000;
   logic mclk = 1'b0;
   logic arst_n, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   wire [1:0] pclk, mode, dq_oe;
   wire [12:0] addr [2];
   wire [8:0] dq [2];
   wire [8:0] dq_out [2];
   wire [6:0] ctl [2];
   logic [8:0] mem [8192];
   logic [12:0] cnt [2];
   logic [12:0] ra [6];
   logic [1:0] en = 2'h3;
   logic [9:0] pipe [2][$];
   logic [9:0] qd [2][$];
   logic [33:0] qp [$];
   logic [33:0] pe;
   int n_errors = 0;
   int num_checks = 0;
   int cyc_cnt = 0;

   always #2 mclk = ~mclk;

   dps_top i_dut (
      .MCLK(mclk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
      .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .A_CLK(pclk[0]), .A_ADDR(addr[0]), .A_DQ_IN(dq[0]), .A_DQ_OUT(dq_out[0]), .A_DQ_OE(dq_oe[0]),
      .A_ADDRESS_STROBE_N(ctl[0][6]), .A_COUNT_ENABLE_N(ctl[0][5]), .A_COUNTER_CLEAR_N(ctl[0][4]),
      .A_SELECT_LOW_ACTIVE_N(ctl[0][3]), .A_SELECT_HIGH_ACTIVE(ctl[0][2]), .A_WRITE_NOT_READ(ctl[0][1]),
      .A_OUTPUT_DRIVE_N(ctl[0][0]), .A_FLOWTHRU_OR_PIPED_SEL(mode[0]),
      .B_CLK(pclk[1]), .B_ADDR(addr[1]), .B_DQ_IN(dq[1]), .B_DQ_OUT(dq_out[1]), .B_DQ_OE(dq_oe[1]),
      .B_ADDRESS_STROBE_N(ctl[1][6]), .B_COUNT_ENABLE_N(ctl[1][5]), .B_COUNTER_CLEAR_N(ctl[1][4]),
      .B_SELECT_LOW_ACTIVE_N(ctl[1][3]), .B_SELECT_HIGH_ACTIVE(ctl[1][2]), .B_WRITE_NOT_READ(ctl[1][1]),
      .B_OUTPUT_DRIVE_N(ctl[1][0]), .B_FLOWTHRU_OR_PIPED_SEL(mode[1]));
   dps_host #(.PIPED(1'b0)) i_host_a (.mclk(mclk), .pclk(pclk[0]), .addr(addr[0]), .dq(dq[0]),
      .ctl(ctl[0]), .mode(mode[0]));
   dps_host #(.PIPED(1'b1)) i_host_b (.mclk(mclk), .pclk(pclk[1]), .addr(addr[1]), .dq(dq[1]),
      .ctl(ctl[1]), .mode(mode[1]));

   task automatic stop_test;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : stop_test

   task automatic cmp_dq(input logic [9:0] got, input logic [9:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %0t pins got %h exp %h", $time, got, exp);
      end
   endtask : cmp_dq

   task automatic cmp_apb(input logic [33:0] got, input logic [33:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %0t apb got %h exp %h", $time, got, exp);
      end
   endtask : cmp_apb

   // one apb transfer, held until pready is seen high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [33:0] e);
      qp.push_back(e);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // port cycle plus reference model; note shows up lat port edges later (flow 1, piped 2)
   task automatic pcyc(input int p, input logic [6:0] c, input logic [12:0] a, input logic [8:0] d);
      logic [9:0] e;
      if (!c[4]) cnt[p] = 13'h0000;
      else if (!c[6]) cnt[p] = a;
      else if (!c[5]) cnt[p] = cnt[p] + 13'h0001;
      if (!c[3] && c[2] && en[p] && !c[1]) mem[cnt[p]] = d;
      e = (!c[3] && c[2] && en[p] && c[1]) ? {1'b1, mem[cnt[p]]} : 10'h000;
      pipe[p].push_back(e);
      if (pipe[p].size() > p + 1) begin
         e = pipe[p].pop_front();
         qd[p].push_back(c[0] ? 10'h000 : e);
      end
      if (p == 0) i_host_a.cyc(c, a, d);
      else i_host_b.cyc(c, a, d);
   endtask : pcyc

   // apb results, taken at the edge that completes the access
   always @(posedge mclk) begin
      if (psel && penable && pready === 1'b1) begin
         pe = qp.pop_front();
         cmp_apb({pe[33], pslverr, pe[33] ? 32'h0000_0000 : prdata}, pe);
      end
   end

   // pin state sampled half an mclk after each port rise, well after the previous access settled
   for (genvar p = 0; p < 2; p++) begin : g_mon
      logic [9:0] n;
      always @(posedge pclk[p]) begin
         @(negedge mclk);
         if (qd[p].size() > 0) begin
            n = qd[p].pop_front();
            cmp_dq({dq_oe[p], dq_out[p] & {9{dq_oe[p]}}}, n);
         end
      end
   end

   // hang guard, far above the roughly 370 cycles the run needs
   always @(posedge mclk) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 20000) begin
         n_errors++;
         stop_test();
      end
   end

   initial begin
      arst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      cnt[0] = 13'h0000;
      cnt[1] = 13'h0000;
      void'($urandom(32'h4a12));
      repeat (4) @(posedge mclk);
      arst_n <= 1'b1;
      repeat (4) @(posedge mclk);
      apb(1'b0, dps_pkg::REG_PORT_CTRL, 32'h0000_0000, {32'h0000_0000, dps_pkg::CTRL_RST});
      apb(1'b0, 12'h010, 32'h0000_0000, 34'h1_0000_0000);
      // random words written on port a, all but the fourth read back on piped port b
      for (int i = 0; i < 6; i++) begin
         ra[i] = 13'($urandom());
         pcyc(0, WR_LD, ra[i], 9'($urandom()));
      end
      pcyc(0, IDLE, 13'h0000, 9'h000);
      for (int i = 0; i < 6; i++) pcyc(1, (i == 3) ? DS_H : RD_LD, ra[i], 9'h000);
      for (int i = 0; i < 3; i++) pcyc(1, IDLE, 13'h0000, 9'h000);
      // burst across the top of the array, then counter modes on reads
      pcyc(0, WR_LD, 13'h1FFE, 9'($urandom()));
      for (int i = 0; i < 3; i++) pcyc(0, WR_INC, 13'h0ABC, 9'($urandom()));
      pcyc(0, CLR_ALL, 13'h1FFE, 9'h000);
      pcyc(0, RD_INC, 13'h1FFE, 9'h000);
      pcyc(0, RD_HOLD, 13'h1FFE, 9'h000);
      pcyc(0, DS_INC, 13'h1FFE, 9'h000);
      pcyc(0, RD_LD, 13'h1FFF, 9'h000);
      pcyc(0, RD_INC, 13'h0100, 9'h000);
      pcyc(0, RD_OEH, 13'h1FFE, 9'h000);
      pcyc(0, DS_H, 13'h0001, 9'h000);
      pcyc(0, WR_LD, 13'h0001, 9'($urandom()));
      pcyc(0, RD_HOLD, 13'h0002, 9'h000);
      // b writes the word a reads in the same port cycle; the unsettled read is masked by drive high
      ra[0] = 13'($urandom());
      fork
         pcyc(0, RD_LD, ra[0], 9'h000);
         pcyc(1, WR_LD, ra[0], 9'($urandom()));
      join
      pcyc(0, RD_OEH, ra[0], 9'h000);
      pcyc(0, RD_HOLD, 13'h0000, 9'h000);
      pcyc(0, IDLE, 13'h0000, 9'h000);
      apb(1'b0, dps_pkg::REG_CNT_A, 32'h0000_0000, {21'h00_0000, cnt[0]});
      // port b switched off, reads give no drive
      apb(1'b1, dps_pkg::REG_PORT_CTRL, 32'h0000_0001, WOK);
      apb(1'b0, dps_pkg::REG_PORT_CTRL, 32'h0000_0000, 34'h0_0000_0001);
      en = 2'h1;
      for (int i = 0; i < 4; i++) pcyc(1, (i < 2) ? RD_INC : IDLE, 13'h0000, 9'h000);
      apb(1'b0, dps_pkg::REG_CNT_B, 32'h0000_0000, {21'h00_0000, cnt[1]});
      apb(1'b1, dps_pkg::REG_PORT_CTRL, 32'h0000_0003, WOK);
      en = 2'h3;
      // let the apb monitor take the last result before the verdict
      repeat (2) @(posedge mclk);
      stop_test();
   end
endmodule : tb
